// >>> src/xpsw_pkg.sv
package xpsw_pkg;
    localparam int X_LINES = 12;
    localparam int Y_LINES = 8;
    localparam logic [3:0] SLV_ADDR_HI = 4'hE;
    localparam int CMD_STATE_BIT = 15;
    localparam int CMD_X_HI = 14;
    localparam int CMD_X_LO = 11;
    localparam int CMD_Y_HI = 10;
    localparam int CMD_Y_LO = 8;
    localparam int CMD_UPD_BIT = 0;
    localparam int CODE_MSB_BIT = 7;
    localparam int CODE_BIT6 = 6;
    localparam int CODE_BIT3 = 3;
    localparam logic [7:0] CODE_FIXED_MASK = 8'hB4;
    localparam logic [7:0] CODE_FIXED_VAL = 8'h34;
    localparam logic [7:0] READ_FIRST_BYTE = 8'h00;
    localparam logic [3:0] BIT_CNT_LAST = 4'h7;
    localparam int SCL_DIV = 4;
    localparam logic [7:0] X_CODE_GAP_LO = 8'h06;
    localparam logic [3:0] X_GAP_ADJ = 4'h2;
endpackage

// >>> src/xpsw_link_if.sv
interface xpsw_link_if;
    logic scl;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda_hst_o;
    logic sda_hst_oe;
    wire  sda = !((sda_dev_oe && !sda_dev_o) || (sda_hst_oe && !sda_hst_o));
    modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport hst (output scl, input sda, output sda_hst_o, output sda_hst_oe);
endinterface

// >>> src/xpsw_dev.sv
// Contract
// - Address with write bit, device acknowledges low
// - Master sends exactly two data bytes
// - Write changes only the selected switch
// - Any switch state readable for debug
// - Readback is select write then read
// - Select byte then one don't-care byte
// - Select write copies X line to holder
// - Read transfer uses direction bit one
// - First read byte is all zeros
// - Second read byte: one means closed
// - Readback code bit layout decode
// - Bits 14..11 select X, gaps reserved
// - Bits 10..8 select Y line
// - Bit 15 closes or opens switch
// - Bit 0 one applies all latched settings
module xpsw_dev #(
    parameter int                 X_N      = xpsw_pkg::X_LINES,
    parameter int                 Y_N      = xpsw_pkg::Y_LINES
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    xpsw_link_if.dev               link,
    input  wire logic [2:0]        addr_pins,
    input  wire logic              sw_reset_n,
    output logic [X_N*Y_N-1:0]     switch_state
);
    // Only the 12 by 8 array is decoded below
    if (X_N != xpsw_pkg::X_LINES || Y_N != xpsw_pkg::Y_LINES) begin : g_size_check
        $error("xpsw_dev supports only 12 by 8");
    end

    // Frame phases of the serial engine
    typedef enum logic [2:0] {
        XPSW_IDLE,   // Between frames
        XPSW_ADDR,   // Shifting the address byte
        XPSW_WR,     // Receiving the command bytes
        XPSW_RD,     // Returning zero byte, then the held row
        XPSW_SKIP    // Frame for another device, or finished
    } xpsw_st_t;

    // Protocol state, shift registers and switch copies
    xpsw_st_t            st_r;
    logic                scl_d_r;
    logic                sda_d_r;
    logic [3:0]          bcnt_r;
    logic [7:0]          sh_r;
    logic                ack_r;       // Acknowledge to drive in the next slot
    logic                ack_slot_r;
    logic [1:0]          byte_r;
    logic [7:0]          b0_r;
    logic [7:0]          hold_r;
    logic [7:0]          tx_r;
    logic [X_N*Y_N-1:0]  latch_r;     // Written by every command with a valid X code while the reset pin is high
    logic [X_N*Y_N-1:0]  sw_r;        // Applied state, copied from latch_nxt
    logic                oe_r;

    // Bus event detection on sampled pins
    wire scl_rise = link.scl && !scl_d_r;
    wire scl_fall = !link.scl && scl_d_r;
    wire start_c  = link.scl && scl_d_r && sda_d_r && !link.sda;
    wire stop_c   = link.scl && scl_d_r && !sda_d_r && link.sda;
    wire [7:0] rx_byte = {sh_r[6:0], link.sda};
    wire addr_hit = rx_byte[7:4] == xpsw_pkg::SLV_ADDR_HI && rx_byte[3:1] == addr_pins;

    // Command word fields from two data bytes
    wire [15:0] cmd = {b0_r, rx_byte};
    wire [3:0]  x_line_select = cmd[xpsw_pkg::CMD_X_HI:xpsw_pkg::CMD_X_LO];
    wire [2:0]  y_line_select = cmd[xpsw_pkg::CMD_Y_HI:xpsw_pkg::CMD_Y_LO];
    wire        switch_update_flag = cmd[xpsw_pkg::CMD_UPD_BIT];
    wire        x_reserved = x_line_select[2:1] == 2'h3;
    // Codes 8..13 map to lines 6..11
    wire [3:0]  x_idx = x_line_select[3] ? x_line_select - xpsw_pkg::X_GAP_ADJ : x_line_select;

    // Readback code: which X line, if any
    wire        readback_code_msb  = b0_r[xpsw_pkg::CODE_MSB_BIT];
    wire        readback_code_bit6 = b0_r[xpsw_pkg::CODE_BIT6];
    wire        readback_code_bit3 = b0_r[xpsw_pkg::CODE_BIT3];
    wire [3:0]  rb_x = {b0_r[1:0], readback_code_bit6, readback_code_bit3};
    wire        rb_sel = !readback_code_msb && (b0_r & xpsw_pkg::CODE_FIXED_MASK) == xpsw_pkg::CODE_FIXED_VAL
                         && rb_x < 4'(X_N);

    function automatic logic [Y_N-1:0] xrow(input logic [X_N*Y_N-1:0] a, input logic [3:0] x);
        xrow = a[x*Y_N +: Y_N];
    endfunction

    // Command completes on the last bit of the second data byte
    // Reserved codes, readback codes and a low reset pin change no switch
    wire cmd_done = st_r == XPSW_WR && scl_rise && bcnt_r == xpsw_pkg::BIT_CNT_LAST && byte_r == 2'h1 && !ack_slot_r;
    wire do_cmd   = cmd_done && !rb_sel && !x_reserved && sw_reset_n;

    // Latch next value: only the addressed bit changes
    logic [X_N*Y_N-1:0] latch_nxt;
    always_comb begin
        latch_nxt = latch_r;
        if (do_cmd)
            latch_nxt[x_idx*Y_N + y_line_select] = cmd[xpsw_pkg::CMD_STATE_BIT];
    end

    // Clock rises that carry a bit of a frame for us
    wire bit_rise   = scl_rise && st_r != XPSW_IDLE && st_r != XPSW_SKIP;
    wire byte_end   = bcnt_r == xpsw_pkg::BIT_CNT_LAST;
    // Strobes into the switch arrays and the readback holder
    wire sw_load    = do_cmd && switch_update_flag;
    wire hold_load  = cmd_done && rb_sel;
    // Read data: low for a zero bit, released once both bytes are out
    wire rd_bit_low = st_r == XPSW_RD && !tx_r[7] && byte_r != 2'h2;
    wire oe_nxt     = ack_slot_r ? ack_r : rd_bit_low;

    // Pin history for edge and condition detection
    always_ff @(posedge clk) begin
        scl_d_r <= link.scl;
        sda_d_r <= link.sda;
    end

    // Switch arrays; the reset pin clears both copies at once
    always_ff @(posedge clk) begin
        if (!rst_n || !sw_reset_n) begin
            latch_r <= '0;
            sw_r    <= '0;
        end else begin
            latch_r <= latch_nxt;
            if (sw_load)
                sw_r <= latch_nxt;
        end
    end

    // Readback holder captured on select write
    always_ff @(posedge clk) begin
        if (!rst_n)
            hold_r <= '0;
        else if (hold_load)
            hold_r <= xrow(sw_r, rb_x);
    end

    // Data line drive changes only just after a falling clock,
    // so the line is steady for the whole high phase
    always_ff @(posedge clk) begin
        if (!rst_n || start_c || stop_c)
            oe_r <= 1'b0;
        else if (scl_fall)
            oe_r <= oe_nxt;
    end

    // Serial protocol engine; ack slot is the ninth bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= XPSW_IDLE;
            bcnt_r <= '0;
            sh_r <= '0;
            ack_r <= 1'b0;
            ack_slot_r <= 1'b0;
            byte_r <= '0;
            b0_r <= '0;
            tx_r <= '0;
        end else if (start_c) begin
            st_r <= XPSW_ADDR;
            bcnt_r <= '0;
            ack_slot_r <= 1'b0;
            byte_r <= '0;
        end else if (stop_c) begin
            // Stop ends any frame; only a new start wakes the engine
            st_r <= XPSW_IDLE;
        end else if (bit_rise) begin
            if (ack_slot_r) begin
                // Ninth clock: in a read, note the master's answer
                ack_slot_r <= 1'b0;
                ack_r <= (st_r == XPSW_RD) ? !link.sda : 1'b0;
                if (st_r == XPSW_RD && link.sda)
                    st_r <= XPSW_SKIP;  // Master nack ends the read
            end else begin
                sh_r <= rx_byte;
                if (byte_end) begin
                    bcnt_r <= '0;
                    ack_slot_r <= 1'b1;
                    if (st_r == XPSW_ADDR) begin
                        // Answer only our own address
                        st_r  <= !addr_hit ? XPSW_SKIP : (rx_byte[0] ? XPSW_RD : XPSW_WR);
                        ack_r <= addr_hit;
                        tx_r  <= xpsw_pkg::READ_FIRST_BYTE;
                    end else if (st_r == XPSW_WR) begin
                        // First byte kept; the second completes the command
                        if (byte_r == 2'h0)
                            b0_r <= rx_byte;
                        byte_r <= byte_r + 2'h1;
                        ack_r  <= byte_r < 2'h2;
                    end else begin
                        // Master answers read bytes, so stay off the line
                        ack_r  <= 1'b0;
                        byte_r <= byte_r + 2'h1;
                        tx_r   <= hold_r;
                    end
                end else begin
                    bcnt_r <= bcnt_r + 4'h1;
                    if (st_r == XPSW_RD)
                        tx_r <= {tx_r[6:0], 1'b0};
                end
            end
        end
    end

    assign link.sda_dev_o  = 1'b0;
    assign link.sda_dev_oe = oe_r;
    assign switch_state    = sw_r;
endmodule

// >>> src/xpsw_host.sv
module xpsw_host (
    input  wire logic        clk,
    input  wire logic        rst_n,
    xpsw_link_if.hst         link,
    input  wire logic        go,
    input  wire logic        rd,
    input  wire logic [6:0]  dev_addr,
    input  wire logic [15:0] wdata,
    output logic             busy,
    output logic             done,
    output logic             nack,
    output logic [15:0]      rdata
);
    typedef enum logic [2:0] {XPSH_IDLE, XPSH_START, XPSH_BIT, XPSH_STOP, XPSH_END} xpsh_st_t;

    xpsh_st_t    st_r;
    logic [1:0]  ph_r;
    logic [$clog2(xpsw_pkg::SCL_DIV)-1:0] div_r;
    logic [4:0]  bit_r;
    logic [1:0]  byte_r;
    logic [26:0] tx_r;
    logic [15:0] rx_r;
    logic        scl_r, sda_r, rd_r, busy_r, done_r, nack_r;

    wire tick   = div_r == '0;
    wire is_ack = bit_r == 5'h8;
    // Read: host releases data bits, acks first data byte, nacks the last
    wire host_bit = rd_r && byte_r != 2'h0 ? !(byte_r == 2'h1 && is_ack) : (is_ack ? 1'b1 : tx_r[26]);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= XPSH_IDLE; ph_r <= '0; div_r <= '0; bit_r <= '0; byte_r <= '0;
            tx_r <= '0; rx_r <= '0; scl_r <= 1'b1; sda_r <= 1'b1; rd_r <= 1'b0;
            busy_r <= 1'b0; done_r <= 1'b0; nack_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            div_r <= tick ? $bits(div_r)'(xpsw_pkg::SCL_DIV - 1) : div_r - 1'b1;
            case (st_r)
                XPSH_IDLE: if (go) begin
                    // Address, then two data bytes on writes
                    tx_r <= {dev_addr, rd, 1'b1, wdata[15:8], 1'b1, wdata[7:0], 1'b1};
                    rd_r <= rd; busy_r <= 1'b1; nack_r <= 1'b0; st_r <= XPSH_START;
                    ph_r <= '0; bit_r <= '0; byte_r <= '0;
                end
                XPSH_START: if (tick) begin
                    sda_r <= 1'b0;
                    st_r <= XPSH_BIT;
                end
                XPSH_BIT: if (tick) begin
                    ph_r <= ph_r + 2'h1;
                    case (ph_r)
                        2'h0: begin scl_r <= 1'b0; end
                        2'h1: begin sda_r <= host_bit; end
                        2'h2: begin scl_r <= 1'b1; end
                        default: begin
                            if (is_ack && byte_r == 2'h0 || is_ack && !rd_r)
                                nack_r <= nack_r | link.sda;
                            if (rd_r && byte_r != 2'h0 && !is_ack)
                                rx_r <= {rx_r[14:0], link.sda};
                            tx_r <= {tx_r[25:0], 1'b1};
                            if (is_ack) begin
                                bit_r <= '0;
                                byte_r <= byte_r + 2'h1;
                                if (byte_r == 2'h2 || (byte_r == 2'h0 && link.sda))
                                    st_r <= XPSH_STOP;
                            end else
                                bit_r <= bit_r + 5'h1;
                        end
                    endcase
                end
                XPSH_STOP: if (tick) begin
                    ph_r <= ph_r + 2'h1;
                    case (ph_r)
                        2'h0: scl_r <= 1'b0;
                        2'h1: sda_r <= 1'b0;
                        2'h2: scl_r <= 1'b1;
                        default: begin sda_r <= 1'b1; st_r <= XPSH_END; end
                    endcase
                end
                default: begin
                    busy_r <= 1'b0; done_r <= 1'b1; st_r <= XPSH_IDLE;
                end
            endcase
        end
    end

    assign link.scl        = scl_r;
    assign link.sda_hst_o  = 1'b0;
    assign link.sda_hst_oe = !sda_r;
    assign busy  = busy_r;
    assign done  = done_r;
    assign nack  = nack_r;
    assign rdata = rx_r;
endmodule

// >>> bench/xpsw_properties.sv
module xpsw_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic sda_hst_o,
    input wire logic sda_hst_oe
);
    logic       scl_q, sda_q, rd_r, ack_r;
    logic [3:0] bit_r, byte_r;
    logic [7:0] sh_r;
    // Edge and bus condition decode from the resolved wire
    wire rise  = scl && !scl_q;
    wire start = scl && scl_q && sda_q && !sda;
    wire stop  = scl && scl_q && !sda_q && sda;
    // Frame tracker; bit 8 of each byte is the acknowledge slot
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {scl_q, sda_q, rd_r, ack_r} <= 4'hC;
            {bit_r, byte_r, sh_r} <= 16'h0000;
        end else begin
            {scl_q, sda_q} <= {scl, sda};
            if (start) begin
                {bit_r, byte_r} <= 8'h00;
            end else if (rise && bit_r == 4'h8) begin
                {bit_r, byte_r} <= {4'h0, byte_r + 4'h1};
            end else if (rise) begin
                {bit_r, sh_r} <= {bit_r + 4'h1, sh_r[6:0], sda};
            end
            if (rise && byte_r == 4'h0 && bit_r == 4'h7) rd_r <= sda;
            if (rise && byte_r == 4'h0 && bit_r == 4'h8) ack_r <= !sda;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rise;
        rise;
    endsequence
    property p_reset_idle; $rose(rst_n) |-> scl && !sda_dev_oe && !sda_hst_oe; endproperty
    property p_dev_hold; scl && scl_q |-> $stable(sda_dev_oe && !sda_dev_o); endproperty
    property p_start_host; start |-> sda_hst_oe && !sda_hst_o; endproperty
    property p_stop_free; stop |-> !sda_dev_oe; endproperty
    property p_addr_quiet; s_rise ##0 (byte_r == 4'h0 && bit_r < 4'h8) |-> !sda_dev_oe; endproperty
    property p_ack_match; s_rise ##0 (byte_r == 4'h0 && bit_r == 4'h8 && sh_r[7:4] != 4'hE) |-> sda; endproperty
    property p_write_ack;
        s_rise ##0 (ack_r && !rd_r && byte_r inside {4'h1, 4'h2} && bit_r == 4'h8) |-> !sda;
    endproperty
    property p_read_zero;
        s_rise ##0 (ack_r && rd_r && byte_r == 4'h1 && bit_r < 4'h8) |-> !sda && !sda_hst_oe;
    endproperty
    property p_read_release;
        s_rise ##0 (ack_r && rd_r && byte_r inside {4'h1, 4'h2} && bit_r == 4'h8) |-> !sda_dev_oe;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("link not idle after reset");
    a_dev_hold: assert property (p_dev_hold) else $error("device moved sda while scl high");
    a_start_host: assert property (p_start_host) else $error("start not made by host");
    a_stop_free: assert property (p_stop_free) else $error("device holds sda at stop");
    a_addr_quiet: assert property (p_addr_quiet) else $error("device drove during address");
    a_ack_match: assert property (p_ack_match) else $error("foreign address acknowledged");
    a_write_ack: assert property (p_write_ack) else $error("data byte not acknowledged");
    a_read_zero: assert property (p_read_zero) else $error("first read byte not zero");
    a_read_release: assert property (p_read_release) else $error("device drove master ack slot");
endmodule

// >>> bench/xpsw_tb.sv
module xpsw_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, go, rd, sw_reset_n, busy, done, nack;
    logic [2:0]  addr_pins;
    logic [6:0]  dev_addr;
    logic [15:0] wdata, rdata;
    logic [95:0] switch_state, lat_m, app_m;
    logic [7:0]  hold_m;
    int          bad_count, compares, cyc, seed, x;
    xpsw_link_if link ();
    xpsw_dev i_xpsw_dev (.clk(clk), .rst_n(rst_n), .link(link), .addr_pins(addr_pins),
        .sw_reset_n(sw_reset_n), .switch_state(switch_state));
    xpsw_host i_xpsw_host (.clk(clk), .rst_n(rst_n), .link(link), .go(go), .rd(rd), .dev_addr(dev_addr),
        .wdata(wdata), .busy(busy), .done(done), .nack(nack), .rdata(rdata));
    xpsw_properties i_xpsw_properties (.clk(clk), .rst_n(rst_n), .scl(link.scl), .sda(link.sda),
        .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe), .sda_hst_o(link.sda_hst_o),
        .sda_hst_oe(link.sda_hst_oe));
    // Free running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic give_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [95:0] exp, input logic [95:0] got);
        compares++;
        if (exp !== got) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One host transfer; request pulsed for one cycle, bounded wait for done
    task automatic xfer(input logic r, input logic [6:0] a, input logic [15:0] d);
        int n;
        @(posedge clk);
        #1 {go, rd, dev_addr, wdata} = {1'b1, r, a, d};
        @(posedge clk);
        #1 go = 1'b0;
        check("busy", 96'h1, 96'(busy));
        n = 0;
        while (done !== 1'b1 && n < 5000) begin
            @(posedge clk);
            #1 n++;
        end
        check("done", 96'h1, 96'(done));
    endtask
    // Two byte write with the reference model updated from the rules
    task automatic cmd(input logic [15:0] c);
        logic [3:0] xf;
        logic [3:0] xr;
        xf = c[14:11];
        xr = {c[9:8], c[14], c[11]};
        xfer(1'b0, {4'hE, addr_pins}, c);
        check("nack", 96'h0, 96'(nack));
        if (sw_reset_n && xf[2:1] != 2'b11) begin
            lat_m[(xf[3] ? int'(xf) - 2 : int'(xf)) * 8 + int'(c[10:8])] = c[15];
            if (c[0]) app_m = lat_m;
        end else if (sw_reset_n && (c[15:8] & 8'hB4) == 8'h34 && xr < 4'hC) begin
            hold_m = app_m[int'(xr) * 8 +: 8];
        end
        check("switches", app_m, switch_state);
    endtask
    // Bounded run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        seed = 32'h28F256AA;
        {rst_n, go, rd, sw_reset_n, dev_addr, wdata} = {4'h1, 23'h000000};
        {lat_m, app_m, hold_m} = '0;
        addr_pins = 3'($random(seed));
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        check("reset switches", 96'h0, switch_state);
        repeat (40) cmd(16'($random(seed)));
        // Every readback code, then the read that returns the held row
        for (x = 0; x < 12; x++) begin
            cmd({1'b0, x[1], 2'b11, x[0], 1'b1, x[3:2], 8'($random(seed))});
            xfer(1'b1, {4'hE, addr_pins}, 16'h0000);
            check("rdata", {80'h0, 8'h00, hold_m}, {80'h0, rdata});
        end
        xfer(1'b0, {4'hD, addr_pins}, 16'h8001);
        check("foreign nack", 96'h1, 96'(nack));
        check("foreign switches", app_m, switch_state);
        @(posedge clk);
        #1 sw_reset_n = 1'b0;
        {lat_m, app_m} = '0;
        repeat (3) @(posedge clk);
        #1 check("cleared switches", 96'h0, switch_state);
        cmd(16'h8001);
        sw_reset_n = 1'b1;
        repeat (10) cmd(16'($random(seed)) | 16'h0001);
        give_verdict();
    end
endmodule
